/* tb/single_wire_flag_protocol_bench.sv */
// Purpose: self-checking bench joining device and host over the wire.
// Assumes: shortened token timeout and wake-high delay for run time.
// Notes: software-style sequencing goes through host registers only.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; \
	if ((a) !== (e)) begin fail_count++; \
	$display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end

module single_wire_flag_protocol_bench
	import swfp_pkg::*;
;

	////////////////////////////////////////////////////////////////////////
	localparam int TMO_SIM = 20000;
	localparam int WHI_SIM = 100;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic [31:0] reg_rdata;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [BUF_AW-1:0] cmd_rd_addr = 6'h00;
	logic [BUF_AW-1:0] resp_waddr = 6'h00;
	logic [7:0] resp_wdata = 8'h00;
	logic [7:0] pause_sel = 8'h00;
	logic [7:0] cfg_selector = 8'h00;
	logic [7:0] sel_policy = 8'h00;
	logic [7:0] upd_val = 8'h00;
	logic exec_done = 1'b0;
	logic resp_we = 1'b0;
	logic resp_commit = 1'b0;
	logic pause_req = 1'b0;
	logic cfg_locked = 1'b1;
	logic upd_req = 1'b0;
	logic [7:0] cmd_rd_data, cmd_len, sel_wdata;
	logic cmd_done, sel_we, upd_err, asleep, idle, woke, vol_clear;
	logic done_seen = 1'b0;
	logic woke_seen = 1'b0;
	int clr_cnt = 0;
	int fail_count = 0;
	int samples_checked = 0;

	swfp_link_if link();
	swfp_device #(.TMO(TMO_SIM)) i_swfp_device(.sys_clk(sys_clk),
		.resetn(resetn), .link(link), .cmd_rd_addr(cmd_rd_addr),
		.cmd_rd_data(cmd_rd_data), .cmd_len(cmd_len), .cmd_done(cmd_done),
		.exec_done(exec_done), .resp_we(resp_we), .resp_waddr(resp_waddr),
		.resp_wdata(resp_wdata), .resp_commit(resp_commit),
		.pause_req(pause_req), .pause_sel(pause_sel),
		.cfg_selector(cfg_selector), .sel_policy(sel_policy),
		.cfg_locked(cfg_locked), .upd_req(upd_req), .upd_val(upd_val),
		.sel_we(sel_we), .sel_wdata(sel_wdata), .upd_err(upd_err),
		.asleep(asleep), .idle(idle), .woke(woke), .vol_clear(vol_clear));
	swfp_host #(.TMO(TMO_SIM), .WHI(WHI_SIM), .ANS(ANS_CYC)) i_swfp_host(
		.sys_clk(sys_clk), .resetn(resetn), .link(link),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata));
	swfp_props i_swfp_props(.sys_clk(sys_clk), .resetn(resetn),
		.line(link.line), .dev_out(link.dev_out), .dev_oe_n(link.dev_oe_n),
		.host_out(link.host_out), .host_oe_n(link.host_oe_n));

	initial begin
		forever #10 sys_clk = ~sys_clk;
	end

	// Pulses are caught here so a check after a long op still sees them
	always @(posedge sys_clk) begin
		if (cmd_done === 1'b1) done_seen <= 1'b1;
		if (woke === 1'b1) woke_seen <= 1'b1;
		if (vol_clear === 1'b1) clr_cnt <= clr_cnt + 1;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic test_done;
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask

	// Bounded poll: a hung host op ends the run as a mismatch
	task automatic op(input logic [1:0] o, input logic [7:0] b,
		output logic [31:0] s);
		int n;
		reg_write(HR_CMD, {16'h0000, b, 6'h00, o});
		n = 0;
		do begin
			reg_read(HR_STAT, s);
			n++;
		end while (s[ST_BUSY_BIT] !== 1'b0 && n < 30000);
		if (s[ST_BUSY_BIT] !== 1'b0) begin
			`CHK(s[ST_BUSY_BIT], 1'b0)
			test_done();
		end
	endtask

	task automatic recv(input logic [7:0] e);
		logic [31:0] s;
		logic [31:0] d;
		op(OP_RECV, 8'h00, s);
		`CHK(s[ST_OK_BIT], 1'b1)
		reg_read(HR_RXD, d);
		`CHK(d[7:0], e)
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic test_wake_status;
		logic [31:0] s;
		logic [31:0] d;
		`CHK(asleep, 1'b1)
		op(OP_WAKE, 8'h00, s);
		`CHK(woke_seen, 1'b1)
		`CHK(asleep, 1'b0)
		op(OP_SEND, FLAG_XMIT, s);
		recv(WST_COUNT);
		recv(WST_CODE);
		recv(WST_CRC_LO);
		recv(WST_CRC_HI);
		reg_read(4'hC, d);
		`CHK(d, 32'h00000000)
		repeat (TOK_SLOTS * BIT_CYC) @(posedge sys_clk);
		$display("test_wake_status finished");
	endtask

	task automatic test_command;
		logic [31:0] s;
		logic [7:0] pol [4] = '{8'h00, 8'h05, 8'h05, 8'h05};
		logic [7:0] sel [4] = '{8'h07, 8'h00, 8'h09, 8'h09};
		logic [7:0] val [4] = '{8'h03, 8'h04, 8'h06, 8'h08};
		logic [1:0] ex [4] = '{2'b10, 2'b10, 2'b01, 2'b10};
		logic lk [4] = '{1'b1, 1'b1, 1'b1, 1'b0};
		// Two bytes take longer than the shortened timeout in total
		op(OP_SEND, FLAG_CMD, s);
		op(OP_SEND, 8'h01, s);
		`CHK(done_seen, 1'b1)
		`CHK(asleep, 1'b0)
		`CHK(cmd_len, 8'h01)
		@(posedge sys_clk);
		cmd_rd_addr <= 6'h00;
		repeat (2) @(posedge sys_clk);
		#1;
		`CHK(cmd_rd_data, 8'h01)
		for (int i = 0; i < 4; i++) begin
			@(posedge sys_clk);
			cfg_locked <= lk[i];
			sel_policy <= pol[i];
			cfg_selector <= sel[i];
			upd_val <= val[i];
			upd_req <= 1'b1;
			@(posedge sys_clk);
			upd_req <= 1'b0;
			#1;
			`CHK({sel_we, upd_err}, ex[i])
			if (ex[i][1]) `CHK(sel_wdata, val[i])
		end
		@(posedge sys_clk);
		pause_sel <= cfg_selector;
		pause_req <= 1'b1;
		resp_we <= 1'b1;
		resp_waddr <= 6'h00;
		resp_wdata <= 8'h02;
		@(posedge sys_clk);
		pause_req <= 1'b0;
		resp_waddr <= 6'h01;
		resp_wdata <= 8'hC3;
		@(posedge sys_clk);
		resp_we <= 1'b0;
		resp_commit <= 1'b1;
		@(posedge sys_clk);
		resp_commit <= 1'b0;
		exec_done <= 1'b1;
		@(posedge sys_clk);
		exec_done <= 1'b0;
		op(OP_SEND, FLAG_XMIT, s);
		recv(8'h02);
		recv(8'hC3);
		`CHK(idle, 1'b0)
		repeat (TOK_SLOTS * BIT_CYC) @(posedge sys_clk);
		$display("test_command finished");
	endtask

	task automatic test_sleep;
		logic [31:0] s;
		int c;
		c = clr_cnt;
		op(OP_SEND, FLAG_SLEEP, s);
		`CHK(asleep, 1'b1)
		`CHK(clr_cnt, c + 1)
		$display("test_sleep finished");
	endtask

	task automatic test_idle;
		logic [31:0] s;
		op(OP_WAKE, 8'h00, s);
		op(OP_SEND, FLAG_IDLE, s);
		`CHK(idle, 1'b1)
		`CHK(asleep, 1'b0)
		op(OP_WAIT, 8'h00, s);
		op(OP_RECV, 8'h00, s);
		`CHK(s[ST_MISS_BIT], 1'b1)
		`CHK(idle, 1'b1)
		$display("test_idle finished");
	endtask

	initial begin
		repeat (6) @(posedge sys_clk);
		resetn <= 1'b1;
		test_wake_status();
		test_command();
		test_sleep();
		test_idle();
		test_done();
	end

endmodule

`default_nettype wire

/* tb/swfp_props.sv */
// Purpose: wire-level checks on the link between device and host.
// Assumes: sees only the interface signals; one clock, async reset.
// Notes: pulse counters are helper logic; counts follow BIT_CYC.
`timescale 1ns/1ps
`default_nettype none

module swfp_props
	import swfp_pkg::*;
(
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic line,
	input wire logic dev_out,
	input wire logic dev_oe_n,
	input wire logic host_out,
	input wire logic host_oe_n
);

	////////////////////////////////////////////////////////////////////////
	logic dev_lo;
	logic host_lo;
	int dl_cnt;
	int hl_cnt;
	int hq_cnt;
	int df_cnt;

	assign dev_lo = !dev_oe_n && !dev_out;
	assign host_lo = !host_oe_n && !host_out;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			dl_cnt <= 0;
			hl_cnt <= 0;
		end else begin
			dl_cnt <= dev_lo ? dl_cnt + 1 : 0;
			hl_cnt <= host_lo ? hl_cnt + 1 : 0;
		end
	end

	// Saturate so a long quiet spell never wraps into a false low count
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			hq_cnt <= 0;
		end else if (host_lo) begin
			hq_cnt <= 0;
		end else if (hq_cnt < 100000) begin
			hq_cnt <= hq_cnt + 1;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			df_cnt <= 4000;
		end else if ($rose(dev_lo)) begin
			df_cnt <= 1;
		end else if (df_cnt < 4000) begin
			df_cnt <= df_cnt + 1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!resetn);

	a_no_contention: assert property (!(!dev_oe_n && !host_oe_n))
		else $error("both ends enabled on the wire");
	a_line_level: assert property ((dev_lo || host_lo) == !line)
		else $error("wire level does not match drivers");
	a_host_pulse: assert property ($fell(host_lo) |->
		hl_cnt == BIT_CYC || hl_cnt == WAKE_HOLD_CYC)
		else $error("host low pulse has wrong length");
	a_dev_pulse: assert property ($fell(dev_lo) |-> dl_cnt == BIT_CYC)
		else $error("device low pulse has wrong length");
	a_dev_spacing: assert property ($rose(dev_lo) && df_cnt < 1900 |->
		df_cnt == 2 * BIT_CYC || df_cnt == 7 * BIT_CYC)
		else $error("device token spacing wrong");
	a_dev_release: assert property ($fell(dev_lo) |-> line [*8])
		else $error("wire not high after device pulse");
	a_turn_wait: assert property (dev_lo |-> hq_cnt >= TURN_CYC)
		else $error("device drove before turnaround");
	a_reset_idle: assert property ($rose(resetn) |->
		dev_oe_n && host_oe_n)
		else $error("an end drives the wire out of reset");

	c_dev_pulse: cover property ($fell(dev_lo));
	c_wake: cover property ($fell(host_lo) && hl_cnt == WAKE_HOLD_CYC);
	c_dev_zero: cover property ($rose(dev_lo) && df_cnt == 2 * BIT_CYC);

endmodule

`default_nettype wire

/* verilog/swfp_device.sv */
// Purpose: device end of the single-wire flag link.
// Assumes: command execution lives outside and reports by exec_done.
// Notes: response count byte sits at buffer address zero.
//
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module swfp_device
	import swfp_pkg::*;
#(
	parameter int TMO = TMO_CYC
) (
	input wire logic sys_clk,
	input wire logic resetn,
	swfp_link_if.device link,
	input wire logic [BUF_AW-1:0] cmd_rd_addr,
	output logic [7:0] cmd_rd_data,
	output logic [7:0] cmd_len,
	output logic cmd_done,
	input wire logic exec_done,
	input wire logic resp_we,
	input wire logic [BUF_AW-1:0] resp_waddr,
	input wire logic [7:0] resp_wdata,
	input wire logic resp_commit,
	input wire logic pause_req,
	input wire logic [7:0] pause_sel,
	input wire logic [7:0] cfg_selector,
	input wire logic [7:0] sel_policy,
	input wire logic cfg_locked,
	input wire logic upd_req,
	input wire logic [7:0] upd_val,
	output logic sel_we,
	output logic [7:0] sel_wdata,
	output logic upd_err,
	output logic asleep,
	output logic idle,
	output logic woke,
	output logic vol_clear
);

	swfp_dstate_type st_r, st_nxt;
	logic line_q_r;
	logic [11:0] low_r;
	logic tok_act_r, tok_bad_r, lost_r, bit_v_r, bit_r;
	logic [9:0] tok_cnt_r;
	logic [7:0] sh_r;
	logic [2:0] nb_r;
	logic [21:0] tmo_r;
	logic [7:0] cmd_idx_r;
	logic [11:0] turn_r;
	logic resp_valid_r, pause_mis_r;
	logic [7:0] tx_cnt_r, tx_byte_r;
	logic [3:0] tx_slot_r;
	logic [2:0] tx_bit_r;
	logic [7:0] cmd_mem [BUF_DEPTH];
	logic [7:0] resp_mem [BUF_DEPTH];
	logic fall, long_low, wake_seen, rx_en, good, byte_done, armed, expire;
	logic last_byte, pause_now, send_end, to_sleep, wake_load;
	logic [7:0] byte_val, need;

	////////////////////////////////////////////////////////////////////
	// Line watching

	assign fall = line_q_r && !link.line;
	assign long_low = low_r > 12'(ZLO_CYC);
	assign wake_seen = low_r >= 12'(WAKE_CYC);
	// Busy, turnaround and send states see nothing on the wire
	assign rx_en = (st_r == DS_FLAG) || (st_r == DS_CMD);

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			line_q_r <= 1'b1;
			low_r <= 12'h000;
		end else begin
			line_q_r <= link.line;
			if (link.line)
				low_r <= 12'h000;
			else if (low_r != 12'hFFF)
				low_r <= low_r + 12'h001;
		end
	end

	// One token per bit, value read in the slot after the first data bit
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			tok_act_r <= 1'b0;
			tok_bad_r <= 1'b0;
			tok_cnt_r <= 10'h000;
			bit_v_r <= 1'b0;
			bit_r <= 1'b0;
		end else begin
			bit_v_r <= 1'b0;
			if (!rx_en) begin
				tok_act_r <= 1'b0;
				tok_bad_r <= 1'b0;
			end else if (!tok_act_r) begin
				if (fall) begin
					tok_act_r <= 1'b1;
					tok_bad_r <= 1'b0;
					tok_cnt_r <= 10'h000;
				end
			end else begin
				tok_cnt_r <= tok_cnt_r + 10'h001;
				if (long_low)
					tok_bad_r <= 1'b1;
				if (tok_cnt_r == 10'(SAMPLE_CYC - 1)) begin
					tok_act_r <= 1'b0;
					bit_v_r <= !(tok_bad_r || long_low);
					bit_r <= link.line;
				end
			end
		end
	end

	// A bad token leaves the device deaf until the timeout puts it to sleep
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			lost_r <= 1'b0;
		else if (!rx_en)
			lost_r <= 1'b0;
		else if (tok_act_r && tok_cnt_r == 10'(SAMPLE_CYC - 1) &&
			(tok_bad_r || long_low))
			lost_r <= 1'b1;
	end

	assign good = bit_v_r && !lost_r;
	assign byte_val = {bit_r, sh_r[7:1]};
	assign byte_done = good && (nb_r == 3'h7);

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			sh_r <= 8'h00;
			nb_r <= 3'h0;
		end else if (!rx_en) begin
			nb_r <= 3'h0;
		end else if (good) begin
			sh_r <= byte_val;
			nb_r <= nb_r + 3'h1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Token timeout

	assign armed = (st_r == DS_CMD) ||
		(st_r == DS_FLAG && (tok_act_r || nb_r != 3'h0 || lost_r));
	assign expire = armed && (tmo_r == 22'(TMO - 1));

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			tmo_r <= 22'h000000;
		else if (!armed || good)
			tmo_r <= 22'h000000;
		else
			tmo_r <= tmo_r + 22'h000001;
	end

	////////////////////////////////////////////////////////////////////
	// Flag decoding and sequencing

	assign need = (cmd_idx_r == 8'h00) ? byte_val : cmd_len;
	assign last_byte = {1'b0, need} <= ({1'b0, cmd_idx_r} + 9'h001);
	assign pause_now = pause_req && (pause_sel != cfg_selector);
	assign send_end = (st_r == DS_SEND) && (tx_cnt_r == 8'(BIT_CYC - 1)) &&
		(tx_slot_r == 4'(TOK_SLOTS - 1)) && (tx_bit_r == 3'h7) &&
		(({1'b0, tx_byte_r} + 9'h001) >= {1'b0, resp_mem[0]});

	always_comb begin
		st_nxt = st_r;
		unique case (st_r)
			DS_SLEEP, DS_IDLE: if (wake_seen) st_nxt = DS_WAKE;
			DS_WAKE: if (link.line) st_nxt = DS_FLAG;
			DS_FLAG: begin
				if (expire)
					st_nxt = DS_SLEEP;
				else if (byte_done) begin
					if (byte_val == FLAG_SLEEP)
						st_nxt = DS_SLEEP;
					else if (byte_val == FLAG_IDLE)
						st_nxt = DS_IDLE;
					else if (byte_val == FLAG_CMD)
						st_nxt = DS_CMD;
					else if (byte_val == FLAG_XMIT && resp_valid_r)
						st_nxt = DS_TURN;
				end
			end
			DS_CMD: begin
				if (expire)
					st_nxt = DS_SLEEP;
				else if (byte_done && last_byte)
					st_nxt = DS_BUSY;
			end
			DS_BUSY: begin
				if (exec_done)
					st_nxt = (pause_mis_r || pause_now) ? DS_IDLE : DS_FLAG;
			end
			DS_TURN: if (turn_r == 12'(TURN_CYC - 1)) st_nxt = DS_SEND;
			DS_SEND: if (send_end) st_nxt = DS_FLAG;
		endcase
	end

	assign to_sleep = (st_nxt == DS_SLEEP) && (st_r != DS_SLEEP);
	assign wake_load = (st_nxt == DS_WAKE) && (st_r != DS_WAKE);

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			st_r <= DS_SLEEP;
			asleep <= 1'b1;
			idle <= 1'b0;
			woke <= 1'b0;
			vol_clear <= 1'b0;
			cmd_done <= 1'b0;
		end else begin
			st_r <= st_nxt;
			asleep <= st_nxt == DS_SLEEP;
			idle <= st_nxt == DS_IDLE;
			woke <= wake_load;
			vol_clear <= to_sleep;
			cmd_done <= (st_nxt == DS_BUSY) && (st_r != DS_BUSY);
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			cmd_idx_r <= 8'h00;
			cmd_len <= 8'h00;
			turn_r <= 12'h000;
		end else begin
			turn_r <= (st_r == DS_TURN) ? turn_r + 12'h001 : 12'h000;
			if (st_r != DS_CMD)
				cmd_idx_r <= 8'h00;
			else if (byte_done) begin
				cmd_idx_r <= cmd_idx_r + 8'h01;
				if (cmd_idx_r == 8'h00)
					cmd_len <= byte_val;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Buffers

	// Bytes past the buffer end are counted but dropped
	always_ff @(posedge sys_clk) begin
		if (st_r == DS_CMD && byte_done && cmd_idx_r < 8'(BUF_DEPTH))
			cmd_mem[cmd_idx_r[BUF_AW-1:0]] <= byte_val;
		cmd_rd_data <= cmd_mem[cmd_rd_addr];
	end

	// Wake preloads the status block answered on the first transmit
	always_ff @(posedge sys_clk) begin
		if (wake_load) begin
			resp_mem[0] <= WST_COUNT;
			resp_mem[1] <= WST_CODE;
			resp_mem[2] <= WST_CRC_LO;
			resp_mem[3] <= WST_CRC_HI;
		end else if (resp_we)
			resp_mem[resp_waddr] <= resp_wdata;
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			resp_valid_r <= 1'b0;
		else if (wake_load || resp_commit)
			resp_valid_r <= 1'b1;
		else if (to_sleep || resp_we)
			resp_valid_r <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////
	// Response transmitter

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			tx_cnt_r <= 8'h00;
			tx_slot_r <= 4'h0;
			tx_bit_r <= 3'h0;
			tx_byte_r <= 8'h00;
		end else if (st_r != DS_SEND) begin
			tx_cnt_r <= 8'h00;
			tx_slot_r <= 4'h0;
			tx_bit_r <= 3'h0;
			tx_byte_r <= 8'h00;
		end else if (tx_cnt_r != 8'(BIT_CYC - 1)) begin
			tx_cnt_r <= tx_cnt_r + 8'h01;
		end else begin
			tx_cnt_r <= 8'h00;
			if (tx_slot_r != 4'(TOK_SLOTS - 1))
				tx_slot_r <= tx_slot_r + 4'h1;
			else begin
				tx_slot_r <= 4'h0;
				tx_bit_r <= tx_bit_r + 3'h1;
				if (tx_bit_r == 3'h7)
					tx_byte_r <= tx_byte_r + 8'h01;
			end
		end
	end

	// Start slot low, data in the second bit slot, the rest high
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			link.dev_out <= 1'b1;
			link.dev_oe_n <= 1'b1;
		end else begin
			link.dev_oe_n <= st_r != DS_SEND;
			if (tx_slot_r == 4'h0)
				link.dev_out <= 1'b0;
			else if (tx_slot_r == 4'h2)
				link.dev_out <= resp_mem[tx_byte_r[BUF_AW-1:0]][tx_bit_r];
			else
				link.dev_out <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Selector

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			pause_mis_r <= 1'b0;
		else if (st_r != DS_BUSY)
			pause_mis_r <= 1'b0;
		else if (pause_now)
			pause_mis_r <= 1'b1;
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			sel_we <= 1'b0;
			sel_wdata <= 8'h00;
			upd_err <= 1'b0;
		end else begin
			sel_we <= 1'b0;
			upd_err <= 1'b0;
			if (upd_req) begin
				sel_wdata <= upd_val;
				if (sel_policy == 8'h00 || !cfg_locked)
					sel_we <= 1'b1;
				else if (cfg_selector == 8'h00 && upd_val != 8'h00)
					sel_we <= 1'b1;
				else
					upd_err <= 1'b1;
			end
		end
	end

endmodule

`default_nettype wire

/* verilog/swfp_host.sv */
// Purpose: host end of the single-wire flag link, driven by registers.
// Assumes: software sequences flags, blocks and waits itself.
// Notes: one operation at a time; writes while busy are dropped.
`timescale 1ns/1ps
`default_nettype none

module swfp_host
	import swfp_pkg::*;
#(
	parameter int TMO = TMO_CYC,
	parameter int WHI = WHI_CYC,
	parameter int ANS = ANS_CYC
) (
	input wire logic sys_clk,
	input wire logic resetn,
	swfp_link_if.host link,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata
);

	swfp_hstate_type st_r;
	logic [21:0] cnt_r;
	logic [7:0] byte_r, sh_r;
	logic [7:0] tx_cnt_r;
	logic [3:0] tx_slot_r;
	logic [2:0] tx_bit_r, nb_r;
	logic [9:0] tok_cnt_r;
	logic line_q_r, tok_act_r, bit_v_r, bit_r, ok_r, miss_r;
	logic start, tx_end, rx_done, rx_miss;
	swfp_op_type op;

	assign op = swfp_op_type'(reg_wdata[OP_LSB+1:OP_LSB]);
	assign start = reg_wr && reg_addr == HR_CMD && st_r == HS_IDLE;
	assign tx_end = (st_r == HS_TX) && (tx_cnt_r == 8'(BIT_CYC - 1)) &&
		(tx_slot_r == 4'(TOK_SLOTS - 1)) && (tx_bit_r == 3'h7);
	assign rx_done = (st_r == HS_RX) && bit_v_r && (nb_r == 3'h7);
	assign rx_miss = (st_r == HS_RX) && !tok_act_r && (nb_r == 3'h0) &&
		(cnt_r == 22'(ANS - 1));

	////////////////////////////////////////////////////////////////////
	// Sequencer

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			st_r <= HS_IDLE;
			cnt_r <= 22'h000000;
			byte_r <= 8'h00;
		end else begin
			cnt_r <= cnt_r + 22'h000001;
			unique case (st_r)
				HS_IDLE: begin
					cnt_r <= 22'h000000;
					if (start) begin
						byte_r <= reg_wdata[BYTE_LSB+7:BYTE_LSB];
						unique case (op)
							OP_WAKE: st_r <= HS_WLO;
							OP_SEND: st_r <= HS_TX;
							OP_RECV: st_r <= HS_RX;
							OP_WAIT: st_r <= HS_WAIT;
						endcase
					end
				end
				HS_WLO: begin
					if (cnt_r == 22'(WAKE_HOLD_CYC - 1)) begin
						st_r <= HS_WHI;
						cnt_r <= 22'h000000;
					end
				end
				HS_WHI: if (cnt_r == 22'(WHI - 1)) st_r <= HS_IDLE;
				HS_WAIT: if (cnt_r == 22'(TMO - 1)) st_r <= HS_IDLE;
				HS_TX: if (tx_end) st_r <= HS_IDLE;
				HS_RX: begin
					if (tok_act_r || nb_r != 3'h0)
						cnt_r <= cnt_r;
					if (rx_done || rx_miss)
						st_r <= HS_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// Token sender, one token per bit, LSb first

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			tx_cnt_r <= 8'h00;
			tx_slot_r <= 4'h0;
			tx_bit_r <= 3'h0;
		end else if (st_r != HS_TX) begin
			tx_cnt_r <= 8'h00;
			tx_slot_r <= 4'h0;
			tx_bit_r <= 3'h0;
		end else if (tx_cnt_r != 8'(BIT_CYC - 1)) begin
			tx_cnt_r <= tx_cnt_r + 8'h01;
		end else begin
			tx_cnt_r <= 8'h00;
			if (tx_slot_r != 4'(TOK_SLOTS - 1))
				tx_slot_r <= tx_slot_r + 4'h1;
			else begin
				tx_slot_r <= 4'h0;
				tx_bit_r <= tx_bit_r + 3'h1;
			end
		end
	end

	// Wake never goes out unless software asks; an awake device loses sync
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			link.host_out <= 1'b1;
			link.host_oe_n <= 1'b1;
		end else begin
			link.host_oe_n <= !(st_r == HS_WLO || st_r == HS_TX);
			if (st_r == HS_WLO || tx_slot_r == 4'h0)
				link.host_out <= 1'b0;
			else if (tx_slot_r == 4'h2)
				link.host_out <= byte_r[tx_bit_r];
			else
				link.host_out <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Token receiver

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			line_q_r <= 1'b1;
			tok_act_r <= 1'b0;
			tok_cnt_r <= 10'h000;
			bit_v_r <= 1'b0;
			bit_r <= 1'b0;
			sh_r <= 8'h00;
			nb_r <= 3'h0;
		end else begin
			line_q_r <= link.line;
			bit_v_r <= 1'b0;
			if (st_r != HS_RX) begin
				tok_act_r <= 1'b0;
				nb_r <= 3'h0;
			end else if (!tok_act_r) begin
				tok_cnt_r <= 10'h000;
				tok_act_r <= line_q_r && !link.line;
			end else begin
				tok_cnt_r <= tok_cnt_r + 10'h001;
				if (tok_cnt_r == 10'(SAMPLE_CYC - 1)) begin
					tok_act_r <= 1'b0;
					bit_v_r <= 1'b1;
					bit_r <= link.line;
				end
			end
			if (bit_v_r) begin
				sh_r <= {bit_r, sh_r[7:1]};
				nb_r <= nb_r + 3'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Register port

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			ok_r <= 1'b0;
			miss_r <= 1'b0;
		end else if (rx_done)
			ok_r <= 1'b1;
		else if (rx_miss)
			miss_r <= 1'b1;
		else if (start) begin
			ok_r <= 1'b0;
			miss_r <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			reg_rdata <= 32'h00000000;
		else begin
			reg_rdata <= 32'h00000000;
			if (reg_rd && reg_addr == HR_STAT) begin
				reg_rdata[ST_BUSY_BIT] <= st_r != HS_IDLE;
				reg_rdata[ST_OK_BIT] <= ok_r;
				reg_rdata[ST_MISS_BIT] <= miss_r;
			end else if (reg_rd && reg_addr == HR_RXD)
				reg_rdata[7:0] <= sh_r;
		end
	end

endmodule

`default_nettype wire

/* verilog/swfp_link_if.sv */
// Purpose: the shared data wire between device and host.
// Assumes: each end pulls low through its own enable; pull-up otherwise.
// Notes: an end drives the wire while its enable is low.
`timescale 1ns/1ps
`default_nettype none

interface swfp_link_if;
	logic line;
	logic dev_out;
	logic dev_oe_n;
	logic host_out;
	logic host_oe_n;

	assign line = !((!dev_oe_n && !dev_out) || (!host_oe_n && !host_out));

	modport device(input line, output dev_out, output dev_oe_n);
	modport host(input line, output host_out, output host_oe_n);
endinterface

`default_nettype wire

/* verilog/swfp_pkg.sv */
// Purpose: shared constants and types of the single-wire flag link.
// Assumes: sys_clk at 50 MHz; tokens are 230.4 kBaud UART characters.
// Notes on behaviour
// - Host sends eight-bit flag before each transaction
// - Flag 0xCC: sleep, clear volatile state
// - Flag 0xBB: idle, keep key and seed
// - After 0x77, bytes fill command buffer sequentially
// - Host sends only defined flag codes
// - Flag 0x88: turnaround wait, then send response
// - Repeated transmit flag resends valid buffer
// - Wake leaves low power, clears watchdog; here there is no watchdog
// - Busy device ignores line and flags
// - Host waits execution delay after command
// - Token gap or long low: sleep on timeout
// - Timeout armed until last command bit received
// - Timeout counter restarts on every legal token
// - Timeout monitor disabled while busy
// - Idle device answers transmit within turnaround; here idle ignores flags until wake
// - Resync: timeout, transmit, wake, wait, transmit
// - Only matching selector stays awake on pause
// - Policy zero: selector rewritable any time
// - Zero selector at lock: one update allowed
// - Both non-zero at lock: update always errors
// - Token per bit, LSb first, 0x7F/0x7D
// - Sleeping device waits wake; no wake when awake
`default_nettype none

package swfp_pkg;

	localparam int CLK_MHZ = 50;
	localparam int TOKEN_BIT_NS = 4340;
	localparam int BIT_CYC = TOKEN_BIT_NS * CLK_MHZ / 1000;
	localparam int TOK_SLOTS = 9;
	localparam int SAMPLE_CYC = BIT_CYC * 5 / 2;
	localparam int ZERO_LOW_MAX_NS = 8680;
	localparam int ZLO_CYC = ZERO_LOW_MAX_NS * CLK_MHZ / 1000;
	localparam int WAKE_LOW_NS = 60000;
	localparam int WAKE_CYC = (WAKE_LOW_NS * CLK_MHZ + 999) / 1000;
	localparam int WAKE_HOLD_CYC = WAKE_CYC + BIT_CYC;
	localparam int TOKEN_TIMEOUT_MS = 45;
	localparam int TMO_CYC = TOKEN_TIMEOUT_MS * CLK_MHZ * 1000;
	localparam int WAKE_HIGH_DELAY_US = 2500;
	localparam int WHI_CYC = WAKE_HIGH_DELAY_US * CLK_MHZ;
	localparam int TURN_MIN_NS = 60000;
	localparam int TURN_CYC = (TURN_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam int TURN_MAX_US = 95;
	localparam int ANS_CYC = TURN_MAX_US * CLK_MHZ;

	localparam logic [7:0] FLAG_SLEEP = 8'hCC;
	localparam logic [7:0] FLAG_IDLE = 8'hBB;
	localparam logic [7:0] FLAG_CMD = 8'h77;
	localparam logic [7:0] FLAG_XMIT = 8'h88;
	localparam logic [7:0] WST_COUNT = 8'h04;
	localparam logic [7:0] WST_CODE = 8'h11;
	localparam logic [7:0] WST_CRC_LO = 8'h33;
	localparam logic [7:0] WST_CRC_HI = 8'h43;

	localparam int BUF_DEPTH = 64;
	localparam int BUF_AW = 6;

	localparam logic [3:0] HR_CMD = 4'h0;
	localparam logic [3:0] HR_STAT = 4'h4;
	localparam logic [3:0] HR_RXD = 4'h8;
	localparam int OP_LSB = 0;
	localparam int BYTE_LSB = 8;
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_OK_BIT = 1;
	localparam int ST_MISS_BIT = 2;

	typedef enum logic [1:0] {OP_WAKE, OP_SEND, OP_RECV, OP_WAIT} swfp_op_type;
	typedef enum {DS_SLEEP, DS_IDLE, DS_WAKE, DS_FLAG, DS_CMD, DS_BUSY,
		DS_TURN, DS_SEND} swfp_dstate_type;
	typedef enum {HS_IDLE, HS_WLO, HS_WHI, HS_TX, HS_RX, HS_WAIT}
		swfp_hstate_type;

endpackage

`default_nettype wire
